// ### rtl/frg_ramp.v
// frequency ramp generator with avalon-mm parameter registers
`timescale 1ns/1ps
`include "frg_defines.vh"

module frg_ramp #(
  parameter [19:0] TICK_CYCLES = `FRG_TICK_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire forward_run_command_i,
  input wire reverse_run_command_i,
  input wire alt_set_select_i,
  input wire inching_active_i,
  output wire [15:0] out_freq_o,
  output reg reverse_dir_o,
  output wire running_o,
  output wire alt_functions_o
);

  localparam [2:0] ST_STOP = 3'b001;
  localparam [2:0] ST_HOLD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;
  localparam [19:0] TICK_LAST = TICK_CYCLES - 20'h00001;

  // saturate a written value to its setting limit
  function [19:0] frg_sat;
    input [31:0] val;
    input [19:0] lim;
    begin
      frg_sat = (val > {12'h000, lim}) ? lim : val[19:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // parameter registers
  reg [19:0] accel_time_setting;
  reg [19:0] decel_time_setting;
  reg [15:0] ramp_reference_frequency;
  reg [19:0] alt_accel_time;
  reg [19:0] alt_decel_time;
  reg [15:0] launch_frequency;
  reg [19:0] launch_hold_time;
  reg [15:0] knee_frequency;
  reg [1:0] ramp_shape_select;
  reg [15:0] floor_frequency;
  reg [1:0] extended_view_select;
  reg [15:0] freq_command;
  reg [15:0] gain_frequency_a;
  reg [15:0] gain_frequency_b;
  reg ack;
  reg [2:0] state;
  reg [23:0] acc;
  wire [19:0] hold_val;
  wire [19:0] launch_val;
  wire wr_en;
  wire ext_ok;

  // one wait cycle per access; request is taken at the edge with ack high
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign wr_en = avs_write_i & ack;
  assign ext_ok = (extended_view_select == 2'h0);
  assign hold_val = (avs_writedata_i[19:0] == `FRG_DISABLE_CODE) ? `FRG_DISABLE_CODE :
                    frg_sat(avs_writedata_i, `FRG_HOLD_MAX);
  // launch limit fits 16 bits, so the saturated value is cut on purpose
  assign launch_val = frg_sat(avs_writedata_i, {4'h0, `FRG_LAUNCH_MAX});

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  // register writes; extended-view gate protects the extended group
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      accel_time_setting <= `FRG_RST_ACCEL;
      decel_time_setting <= `FRG_RST_DECEL;
      ramp_reference_frequency <= `FRG_RST_REF;
      alt_accel_time <= `FRG_RST_ALT_ACCEL;
      alt_decel_time <= `FRG_RST_ALT_DECEL;
      launch_frequency <= `FRG_RST_LAUNCH;
      launch_hold_time <= `FRG_RST_HOLD;
      knee_frequency <= `FRG_RST_KNEE;
      ramp_shape_select <= `FRG_SHAPE_LINEAR;
      floor_frequency <= `FRG_RST_FLOOR;
      extended_view_select <= 2'h0;
      freq_command <= 16'h0000;
      gain_frequency_a <= `FRG_RST_GAIN;
      gain_frequency_b <= `FRG_RST_GAIN;
    end
    else if (wr_en)
    begin
      if (avs_address_i == `FRG_OFS_ACCEL)
        accel_time_setting <= frg_sat(avs_writedata_i, `FRG_TIME_MAX);
      else if (avs_address_i == `FRG_OFS_DECEL)
        decel_time_setting <= frg_sat(avs_writedata_i, `FRG_TIME_MAX);
      else if (avs_address_i == `FRG_OFS_REF && ext_ok)
        ramp_reference_frequency <= avs_writedata_i[15:0]; // gains untouched
      else if (avs_address_i == `FRG_OFS_ALT_ACCEL && ext_ok)
        alt_accel_time <= frg_sat(avs_writedata_i, `FRG_TIME_MAX);
      else if (avs_address_i == `FRG_OFS_ALT_DECEL && ext_ok)
        alt_decel_time <= (avs_writedata_i[19:0] == `FRG_DISABLE_CODE) ? `FRG_DISABLE_CODE :
                          frg_sat(avs_writedata_i, `FRG_TIME_MAX);
      else if (avs_address_i == `FRG_OFS_LAUNCH && ext_ok)
        launch_frequency <= launch_val[15:0];
      else if (avs_address_i == `FRG_OFS_HOLD && ext_ok)
        launch_hold_time <= hold_val;
      else if (avs_address_i == `FRG_OFS_KNEE)
        knee_frequency <= avs_writedata_i[15:0];
      else if (avs_address_i == `FRG_OFS_SHAPE)
        ramp_shape_select <= avs_writedata_i[1:0];
      else if (avs_address_i == `FRG_OFS_FLOOR)
        floor_frequency <= avs_writedata_i[15:0];
      else if (avs_address_i == `FRG_OFS_EXT_VIEW)
        extended_view_select <= avs_writedata_i[1:0];
      else if (avs_address_i == `FRG_OFS_CMD)
        freq_command <= avs_writedata_i[15:0];
      else if (avs_address_i == `FRG_OFS_GAIN_A)
        gain_frequency_a <= avs_writedata_i[15:0];
      else if (avs_address_i == `FRG_OFS_GAIN_B)
        gain_frequency_b <= avs_writedata_i[15:0];
    end
  end

  // read data captured in the wait cycle, unmapped reads as zero
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      avs_readdata_o <= 32'h00000000;
    else if (avs_read_i & ~ack)
    begin
      if (avs_address_i == `FRG_OFS_ACCEL)
        avs_readdata_o <= {12'h000, accel_time_setting};
      else if (avs_address_i == `FRG_OFS_DECEL)
        avs_readdata_o <= {12'h000, decel_time_setting};
      else if (avs_address_i == `FRG_OFS_REF)
        avs_readdata_o <= {16'h0000, ramp_reference_frequency};
      else if (avs_address_i == `FRG_OFS_ALT_ACCEL)
        avs_readdata_o <= {12'h000, alt_accel_time};
      else if (avs_address_i == `FRG_OFS_ALT_DECEL)
        avs_readdata_o <= {12'h000, alt_decel_time};
      else if (avs_address_i == `FRG_OFS_LAUNCH)
        avs_readdata_o <= {16'h0000, launch_frequency};
      else if (avs_address_i == `FRG_OFS_HOLD)
        avs_readdata_o <= {12'h000, launch_hold_time};
      else if (avs_address_i == `FRG_OFS_KNEE)
        avs_readdata_o <= {16'h0000, knee_frequency};
      else if (avs_address_i == `FRG_OFS_SHAPE)
        avs_readdata_o <= {30'h00000000, ramp_shape_select};
      else if (avs_address_i == `FRG_OFS_FLOOR)
        avs_readdata_o <= {16'h0000, floor_frequency};
      else if (avs_address_i == `FRG_OFS_EXT_VIEW)
        avs_readdata_o <= {30'h00000000, extended_view_select};
      else if (avs_address_i == `FRG_OFS_CMD)
        avs_readdata_o <= {16'h0000, freq_command};
      else if (avs_address_i == `FRG_OFS_GAIN_A)
        avs_readdata_o <= {16'h0000, gain_frequency_a};
      else if (avs_address_i == `FRG_OFS_GAIN_B)
        avs_readdata_o <= {16'h0000, gain_frequency_b};
      else if (avs_address_i == `FRG_OFS_STATUS)
        avs_readdata_o <= {11'h000, alt_functions_o, state, reverse_dir_o, acc[23:8]};
      else
        avs_readdata_o <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal synchronisers and control tick
  reg [2:0] pin_meta;
  reg [2:0] pin_sync;
  reg [19:0] tick_cnt;
  wire tick;

  // terminals are asynchronous; the select terminal exists only once assigned
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end
    else
    begin
      pin_meta <= {alt_set_select_i, reverse_run_command_i, forward_run_command_i};
      pin_sync <= pin_meta;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tick_cnt <= 20'h00000;
    else if (tick)
      tick_cnt <= 20'h00000;
    else
      tick_cnt <= tick_cnt + 20'h00001;
  end
  assign tick = (tick_cnt == TICK_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // target and active ramp time
  wire run_req = pin_sync[0] ^ pin_sync[1];
  wire req_dir = pin_sync[1];
  wire alt_ramp = pin_sync[2] & ~inching_active_i;
  wire [15:0] out_freq = acc[23:8];
  wire [15:0] launch_eff = (launch_frequency == 16'h0000) ? `FRG_LAUNCH_ZERO_SUB : launch_frequency;
  wire floor_case = (launch_frequency <= floor_frequency);
  wire cmd_ok = (freq_command >= launch_eff) | floor_case;
  wire [15:0] run_tgt = (floor_case && freq_command < floor_frequency) ? floor_frequency : freq_command;
  reg [15:0] target;
  wire ramp_up = (target > out_freq);
  wire [19:0] acc_time = alt_ramp ? alt_accel_time : accel_time_setting;
  wire [19:0] dec_time = !alt_ramp ? decel_time_setting :
                         (alt_decel_time == `FRG_DISABLE_CODE) ? alt_accel_time : alt_decel_time;
  wire [19:0] t_raw = ramp_up ? acc_time : dec_time;
  wire [19:0] t_eff = (t_raw <= `FRG_TIME_SHORT) ? `FRG_TIME_FLOOR : t_raw;

  always @*
  begin
    target = 16'h0000;
    case (state)
      ST_HOLD: target = launch_eff;
      ST_RUN: target = (run_req && req_dir == reverse_dir_o && cmd_ok) ? run_tgt : 16'h0000;
      default: target = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // step per tick = span * 256 / time, by a sequential divider
  wire [15:0] f_s = ramp_up ? target : out_freq;
  wire s_above = (ramp_shape_select == `FRG_SHAPE_S_A) && (knee_frequency != 16'h0000) &&
                 (f_s >= knee_frequency);
  wire [15:0] span = (ramp_shape_select == `FRG_SHAPE_S_A && knee_frequency != 16'h0000) ?
                     knee_frequency : ramp_reference_frequency;
  wire [31:0] fb2 = knee_frequency * knee_frequency;
  wire [31:0] ff2 = f_s * f_s;
  wire [47:0] f_fb2 = f_s * fb2;
  wire [51:0] num_s9 = f_fb2 * 4'h9;
  wire [34:0] mix = {ff2, 2'h0} + {1'b0, fb2, 2'h0} + {3'h0, fb2};
  wire [54:0] den_s = t_eff * mix;
  // average slope that lands on t = (4 f^2 + 5 fb^2) T / (9 fb^2)
  wire [63:0] div_num = s_above ? {4'h0, num_s9, 8'h00} : {40'h0, span, 8'h00};
  wire [63:0] div_den = s_above ? {9'h000, den_s} : {44'h0, t_eff};
  reg [63:0] dv_rem;
  reg [63:0] dv_quo;
  reg [63:0] dv_den;
  reg [6:0] dv_cnt;
  reg [23:0] step;
  wire [63:0] dv_sh = {dv_rem[62:0], dv_quo[63]};
  wire dv_ge = (dv_sh >= dv_den);

  // restarted every tick so fresh settings take effect next tick
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dv_rem <= 64'h0;
      dv_quo <= 64'h0;
      dv_den <= 64'h1;
      dv_cnt <= 7'h00;
      step <= 24'h000000;
    end
    else if (tick)
    begin
      dv_rem <= 64'h0;
      dv_quo <= div_num;
      dv_den <= div_den;
      dv_cnt <= 7'h40;
    end
    else if (dv_cnt != 7'h00)
    begin
      dv_rem <= dv_ge ? dv_sh - dv_den : dv_sh;
      dv_quo <= {dv_quo[62:0], dv_ge};
      dv_cnt <= dv_cnt - 7'h01;
      if (dv_cnt == 7'h01)
        step <= (dv_quo[62:23] != 40'h0) ? 24'hffffff : {dv_quo[22:0], dv_ge}; // quotient bits 63..24 saturate
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run sequencer and frequency accumulator (8 fraction bits)
  reg [19:0] hold_cnt;
  wire [23:0] tq = {target, 8'h00};
  wire [24:0] up_sum = {1'b0, acc} + {1'b0, step};
  wire [23:0] dn_gap = acc - tq;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_STOP;
      acc <= 24'h000000;
      reverse_dir_o <= 1'b0;
      hold_cnt <= 20'h00000;
    end
    else if (tick)
    begin
      case (state)
        ST_STOP:
        begin
          if (run_req && cmd_ok)
          begin
            acc <= {launch_eff, 8'h00};
            reverse_dir_o <= req_dir;
            hold_cnt <= 20'h00000;
            state <= (launch_hold_time == `FRG_DISABLE_CODE) ? ST_RUN : ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (!run_req || req_dir != reverse_dir_o)
            state <= ST_RUN; // decelerate at once
          else if (hold_cnt + 20'h00001 >= launch_hold_time)
            state <= ST_RUN;
          else
            hold_cnt <= hold_cnt + 20'h00001;
        end
        ST_RUN:
        begin
          if (acc < tq)
            acc <= (up_sum > {1'b0, tq}) ? tq : up_sum[23:0];
          else if (dn_gap > step)
            acc <= acc - step;
          else
            acc <= tq;
          if (acc == 24'h000000 && target == 16'h0000)
          begin
            if (run_req && req_dir != reverse_dir_o && cmd_ok)
            begin
              reverse_dir_o <= req_dir;
              acc <= {launch_eff, 8'h00}; // no hold on reversal
            end
            else
              state <= ST_STOP;
          end
        end
        default: state <= ST_STOP;
      endcase
    end
  end

  assign out_freq_o = out_freq;
  assign running_o = ~state[0];
  // second functions follow the select even during inching
  assign alt_functions_o = pin_sync[2];

endmodule // frg_ramp

// ### rtl/frg_defines.vh
// constants for the frequency ramp generator: offsets, reset values, limits, timing
`ifndef FRG_DEFINES_VH
`define FRG_DEFINES_VH

// register byte offsets on the avalon slave
`define FRG_OFS_ACCEL 6'h00
`define FRG_OFS_DECEL 6'h04
`define FRG_OFS_REF 6'h08
`define FRG_OFS_ALT_ACCEL 6'h0c
`define FRG_OFS_ALT_DECEL 6'h10
`define FRG_OFS_LAUNCH 6'h14
`define FRG_OFS_HOLD 6'h18
`define FRG_OFS_KNEE 6'h1c
`define FRG_OFS_SHAPE 6'h20
`define FRG_OFS_FLOOR 6'h24
`define FRG_OFS_EXT_VIEW 6'h28
`define FRG_OFS_CMD 6'h2c
`define FRG_OFS_GAIN_A 6'h30
`define FRG_OFS_GAIN_B 6'h34
`define FRG_OFS_STATUS 6'h38

// reset values; times in 0.01 s, frequencies in 0.01 hz
`define FRG_RST_ACCEL 20'h001f4
`define FRG_RST_DECEL 20'h001f4
`define FRG_RST_REF 16'h1388
`define FRG_RST_ALT_ACCEL 20'h001f4
`define FRG_RST_ALT_DECEL 20'h0270f
`define FRG_RST_LAUNCH 16'h0032
`define FRG_RST_HOLD 20'h0270f
`define FRG_RST_KNEE 16'h1388
`define FRG_RST_FLOOR 16'h0000
`define FRG_RST_GAIN 16'h1388

// setting limits and special codes
`define FRG_TIME_MAX 20'h57e40
`define FRG_LAUNCH_MAX 16'h1770
`define FRG_HOLD_MAX 20'h003e8
`define FRG_DISABLE_CODE 20'h0270f
`define FRG_TIME_SHORT 20'h00003
`define FRG_TIME_FLOOR 20'h00004
`define FRG_LAUNCH_ZERO_SUB 16'h0001
`define FRG_SHAPE_LINEAR 2'h0
`define FRG_SHAPE_S_A 2'h1

// control tick: 10 ms at a 20 ns clock, i.e. 500000 cycles
`define FRG_TICK_CYCLES 20'h7a120

`endif

// ### sim/frg_motor_model.sv
// behavioural motor power stage fed by the commanded output frequency
`timescale 1ns/1ps

module frg_motor_model (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] freq_i,
  input wire reverse_i,
  input wire enable_i,
  output reg [31:0] phase_o
);
  // rotor phase follows the command; a stopped stage holds, it never creeps
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      phase_o <= 32'h0;
    else if (enable_i)
      phase_o <= reverse_i ? phase_o - {16'h0, freq_i} : phase_o + {16'h0, freq_i};
  end
endmodule // frg_motor_model

// ### sim/frg_ramp_assertions.sv
// port-level checker for the frequency ramp generator
`timescale 1ns/1ps

module frg_ramp_checker #(
  parameter [19:0] TICK_CYCLES = 20'd100
) (
  input wire clk_i,
  input wire rst_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire forward_run_command_i,
  input wire reverse_run_command_i,
  input wire alt_set_select_i,
  input wire inching_active_i,
  input wire [15:0] out_freq_o,
  input wire reverse_dir_o,
  input wire running_o,
  input wire alt_functions_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////
  // edges since reset; the synchroniser history is junk until two have passed
  reg [1:0] since_rst;
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      since_rst <= 2'h0;
    else if (since_rst != 2'h3)
      since_rst <= since_rst + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("first request cycle not stalled");
  wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("stall longer than one cycle");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 6'h3c
    |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  alt_follow_a: assert property (since_rst == 2'h3 |-> alt_functions_o == $past(alt_set_select_i, 2))
    else $error("second functions do not follow select");
  stop_zero_a: assert property (!running_o |-> out_freq_o == 16'h0)
    else $error("stopped with nonzero frequency");
  launch_range_a: assert property ($rose(running_o) |-> out_freq_o != 16'h0 && out_freq_o <= 16'h1770)
    else $error("start frequency out of range");
  turn_at_zero_a: assert property ($changed(reverse_dir_o) |-> $past(out_freq_o) == 16'h0)
    else $error("direction changed while turning");
  tick_gap_a: assert property ($changed(out_freq_o) |=> $stable(out_freq_o) [*8])
    else $error("frequency changed between ticks");
endmodule // frg_ramp_checker

bind frg_ramp frg_ramp_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .forward_run_command_i(forward_run_command_i), .reverse_run_command_i(reverse_run_command_i),
  .alt_set_select_i(alt_set_select_i), .inching_active_i(inching_active_i), .out_freq_o(out_freq_o),
  .reverse_dir_o(reverse_dir_o), .running_o(running_o), .alt_functions_o(alt_functions_o));

// ### sim/frg_ramp_tb_top.sv
// self-checking bench for the frequency ramp generator
`timescale 1ns/1ps
`include "frg_defines.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("BAD %0t got %h want %h", $time, a, b); end end

module frg_ramp_tb_top;
  localparam int TK = 100; // short tick keeps the run small
  logic clk_i = 0;
  logic rst_i = 1;
  logic [5:0] avs_address_i = 0;
  logic avs_read_i = 0;
  logic avs_write_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic fwd = 0;
  logic rev = 0;
  logic alt = 0;
  logic inch = 0;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o;
  wire [15:0] out_freq_o;
  wire reverse_dir_o;
  wire running_o;
  wire alt_functions_o;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h3a22415e;
  logic [31:0] q;
  logic [15:0] v;
  logic [5:0] ra [10] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c, 6'h30, 6'h34};
  logic [19:0] rv [10] = '{`FRG_RST_ACCEL, `FRG_RST_DECEL, `FRG_RST_REF, `FRG_RST_ALT_ACCEL, `FRG_RST_ALT_DECEL,
    `FRG_RST_LAUNCH, `FRG_RST_HOLD, `FRG_RST_KNEE, `FRG_RST_GAIN, `FRG_RST_GAIN};

  frg_ramp #(.TICK_CYCLES(20'd100)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .forward_run_command_i(fwd),
    .reverse_run_command_i(rev), .alt_set_select_i(alt), .inching_active_i(inch), .out_freq_o(out_freq_o),
    .reverse_dir_o(reverse_dir_o), .running_o(running_o), .alt_functions_o(alt_functions_o));
  frg_motor_model u_motor (.clk_i(clk_i), .rst_i(rst_i), .freq_i(out_freq_o), .reverse_i(reverse_dir_o),
    .enable_i(running_o), .phase_o());

  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // one access, held until an edge sees waitrequest low; the watchdog bounds it
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge clk_i);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  // waits for the next change of output frequency, a few dozen ticks at most
  task automatic wchg();
    logic [15:0] f;
    int n;
    @(negedge clk_i);
    f = out_freq_o;
    n = 0;
    while (out_freq_o === f && n < 40 * TK)
    begin
      n++;
      @(negedge clk_i);
    end
  endtask

  // the first change may still use the old step, so measure the second
  task automatic step(input logic [15:0] e);
    logic [15:0] a;
    wchg();
    a = out_freq_o;
    wchg();
    `CHK(a > out_freq_o ? a - out_freq_o : out_freq_o - a, e)
  endtask

  task automatic wrun(input logic r);
    int n;
    n = 0;
    while (running_o !== r && n < 200 * TK)
    begin
      n++;
      @(negedge clk_i);
    end
  endtask

  task automatic weq(input logic [15:0] e);
    int n;
    n = 0;
    while (out_freq_o !== e && n < 200 * TK)
    begin
      n++;
      @(negedge clk_i);
    end
    `CHK(out_freq_o, e)
  endtask

  task automatic tdone(input string s);
    $display("test %0s done", s);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // hang guard, well above the expected forty thousand cycles
  initial
  begin
    #(95000 * 20);
    err_count++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0);
      `CHK(q, {12'h0, rv[i]})
    end
    bus(1'b0, 6'h3c, 32'h0);
    `CHK(q, 32'h0)
    tdone("reset");
    // gated settings only move while the extended view is zero
    bus(1'b1, 6'h28, 32'h1);
    bus(1'b1, 6'h08, 32'h9c4);
    bus(1'b0, 6'h08, 32'h0);
    `CHK(q, 32'h1388)
    bus(1'b1, 6'h28, 32'h0);
    bus(1'b1, 6'h08, 32'h9c4);
    bus(1'b0, 6'h08, 32'h0);
    `CHK(q, 32'h9c4)
    bus(1'b0, 6'h30, 32'h0);
    `CHK(q, 32'h1388)
    bus(1'b1, 6'h08, 32'h1388);
    tdone("access");
    // command under the launch frequency must not start the stage
    bus(1'b1, 6'h14, 32'h1f4);
    bus(1'b1, 6'h00, 32'h64);
    bus(1'b1, 6'h2c, 32'h12c);
    fwd <= 1'b1;
    repeat (5 * TK) @(negedge clk_i);
    `CHK(running_o, 1'b0)
    bus(1'b1, 6'h2c, 32'h9c4);
    wrun(1'b1);
    `CHK(out_freq_o, 16'h1f4)
    step(16'd50);
    weq(16'h9c4);
    bus(1'b1, 6'h00, 32'h2);
    bus(1'b1, 6'h2c, 32'h1770);
    step(16'd1250);
    weq(16'h1770);
    bus(1'b1, 6'h04, 32'hc8);
    bus(1'b1, 6'h2c, 32'hfa0);
    step(16'd25);
    tdone("slopes");
    // alternate pair, shared time through the disable code, inching veto
    @(posedge clk_i);
    alt <= 1'b1;
    bus(1'b1, 6'h0c, 32'h28);
    bus(1'b1, 6'h2c, 32'hbb8);
    step(16'd125);
    `CHK(alt_functions_o, 1'b1)
    @(posedge clk_i);
    inch <= 1'b1;
    bus(1'b1, 6'h2c, 32'h7d0);
    step(16'd25);
    `CHK(alt_functions_o, 1'b1)
    @(posedge clk_i);
    inch <= 1'b0;
    bus(1'b1, 6'h2c, 32'h1388);
    step(16'd125);
    @(posedge clk_i);
    fwd <= 1'b0;
    wrun(1'b0);
    `CHK(out_freq_o, 16'h0)
    tdone("alternate");
    // start hold, zero launch and stop inside the hold
    bus(1'b1, 6'h14, 32'h0);
    bus(1'b1, 6'h18, 32'h14);
    bus(1'b1, 6'h00, 32'h64);
    alt <= 1'b0;
    fwd <= 1'b1;
    wrun(1'b1);
    `CHK(out_freq_o, 16'h1)
    repeat (15 * TK) @(negedge clk_i);
    `CHK(out_freq_o, 16'h1)
    @(posedge clk_i);
    fwd <= 1'b0;
    repeat (5 * TK) @(negedge clk_i);
    `CHK(running_o, 1'b0)
    // reversal passes through zero without holding
    bus(1'b1, 6'h2c, 32'h9c4);
    fwd <= 1'b1;
    weq(16'h9c4);
    @(posedge clk_i);
    fwd <= 1'b0;
    rev <= 1'b1;
    wait (reverse_dir_o === 1'b1);
    repeat (5 * TK) @(negedge clk_i);
    `CHK(out_freq_o > 16'h1, 1'b1)
    @(posedge clk_i);
    rev <= 1'b0;
    wrun(1'b0);
    tdone("hold");
    // launch at or under the floor runs with no command
    bus(1'b1, 6'h24, 32'h3e8);
    bus(1'b1, 6'h14, 32'h1f4);
    bus(1'b1, 6'h2c, 32'h0);
    fwd <= 1'b1;
    weq(16'h3e8);
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      v = 16'h3e8 + {5'h0, seed[10:0]};
      bus(1'b1, 6'h00, {26'h0, seed[21:16]} + 32'h4);
      bus(1'b1, 6'h2c, {16'h0, v});
      weq(v);
    end
    tdone("random");
    // s-curve a: span is the knee below it, stretched average slope above it
    bus(1'b1, 6'h1c, 32'h1b58);
    bus(1'b1, 6'h20, 32'h1);
    bus(1'b1, 6'h00, 32'h64);
    bus(1'b1, 6'h2c, 32'h1770);
    step(16'd70);
    bus(1'b1, 6'h2c, 32'h36b0);
    step(16'd60);
    tdone("s-curve");
    finish_test();
  end
endmodule // frg_ramp_tb_top
